// ==== logic/hpba_port.sv ====
// burst-mode separate-strobe host port with internal location store
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - later read strobe fall with strobe low increments address
// - read drives data at incremented address
// - ready drops right after read strobe falls
// - ready rises once read data settled
// - burst reads return offsets zero, one, onward
// - increment is internal, address pins unchanged
// - latch strobe rise ends burst, stops incrementing
// - after burst, single access or new burst
// - address latched on latch strobe falling edge
// - write strobe low enables data input
// - write strobe rise captures data, ends cycle
// - later write strobe fall increments address
module hpba_port
    import hpba_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // host control pins
    input wire logic cs_n,
    input wire logic addr_latch_strobe,
    input wire logic read_strobe_n,
    input wire logic write_strobe_n,
    input wire logic bus_style_select,
    // host address and data bus
    input wire logic [hpba_pkg::HPBA_AW-1:0] addr,
    input wire logic [hpba_pkg::HPBA_DW-1:0] data_in,
    output logic [hpba_pkg::HPBA_DW-1:0] data_out,
    output logic data_oe,
    // handshake
    output logic ready_ack,
    // status
    output logic burst_active
);
    import hpba_pkg::*;

    localparam int PW = $bits(hpba_pins_t);
    localparam hpba_pins_t PINS_RST = '{cs_n: 1'b1, addr_latch_strobe: 1'b0,
        read_strobe_n: 1'b1, write_strobe_n: 1'b1, bus_style_select: 1'b0};

    hpba_pins_t pins_raw;
    hpba_pins_t pins_s;
    hpba_pins_t pins_q;
    hpba_pins_t pins_d;
    logic [HPBA_AW-1:0] addr_s;
    logic [HPBA_DW-1:0] din_s;

    assign pins_raw = '{cs_n: cs_n, addr_latch_strobe: addr_latch_strobe,
        read_strobe_n: read_strobe_n, write_strobe_n: write_strobe_n,
        bus_style_select: bus_style_select};

    hpba_sync #(.W(PW), .RST_VAL(PINS_RST)) u_sync_pins (
        .core_clk(core_clk),
        .nrst(nrst),
        .din(pins_raw),
        .dout(pins_s)
    );

    hpba_sync #(.W(HPBA_AW), .RST_VAL(HPBA_ADDR_RST)) u_sync_addr (
        .core_clk(core_clk),
        .nrst(nrst),
        .din(addr),
        .dout(addr_s)
    );

    hpba_sync #(.W(HPBA_DW), .RST_VAL(HPBA_DATA_RST)) u_sync_data (
        .core_clk(core_clk),
        .nrst(nrst),
        .din(data_in),
        .dout(din_s)
    );

    // edge detection on synchronised pins
    logic ale_fall;
    logic ale_rise;
    logic rd_fall;
    logic wr_fall;
    logic wr_rise;
    logic sel;
    logic style_ok;

    assign pins_d = pins_s;
    assign sel = !pins_s.cs_n;
    assign style_ok = !pins_s.bus_style_select;
    assign ale_fall = pins_q.addr_latch_strobe && !pins_s.addr_latch_strobe;
    assign ale_rise = !pins_q.addr_latch_strobe && pins_s.addr_latch_strobe;
    assign rd_fall = pins_q.read_strobe_n && !pins_s.read_strobe_n;
    assign wr_fall = pins_q.write_strobe_n && !pins_s.write_strobe_n;
    assign wr_rise = !pins_q.write_strobe_n && pins_s.write_strobe_n;

    function automatic logic [HPBA_AW-1:0] next_addr(input logic [HPBA_AW-1:0] a);
        next_addr = a + HPBA_ADDR_STEP;
    endfunction : next_addr

    // location store
    logic [HPBA_DW-1:0] mem_q [HPBA_DEPTH];

    // control state
    hpba_state_t state_q;
    hpba_state_t state_d;
    logic [HPBA_AW-1:0] addr_q;
    logic [HPBA_AW-1:0] addr_d;
    logic burst_q;
    logic burst_d;
    logic first_q;
    logic first_d;
    logic [3:0] cnt_q;
    logic [3:0] cnt_d;
    logic rdy_q;
    logic rdy_d;
    logic oe_q;
    logic oe_d;
    logic [HPBA_DW-1:0] dout_q;
    logic [HPBA_DW-1:0] dout_d;
    logic mem_we;
    logic [HPBA_AW-1:0] rd_addr;

    always_comb begin
        state_d = state_q;
        addr_d = addr_q;
        burst_d = burst_q;
        first_d = first_q;
        cnt_d = cnt_q;
        rdy_d = rdy_q;
        oe_d = oe_q;
        dout_d = dout_q;
        mem_we = 1'b0;
        rd_addr = addr_q;
        if (sel && style_ok && ale_fall) begin
            addr_d = addr_s;
            burst_d = 1'b1;
            first_d = 1'b1;
        end
        if (ale_rise) begin
            burst_d = 1'b0;
        end
        unique case (state_q)
            HPBA_IDLE: begin
                rdy_d = 1'b1;
                oe_d = 1'b0;
                if (sel && style_ok && rd_fall && pins_s.write_strobe_n) begin
                    // later accesses of a burst step the address first
                    if (burst_q && !first_q && !pins_s.addr_latch_strobe) begin
                        rd_addr = next_addr(addr_q);
                        addr_d = rd_addr;
                    end
                    first_d = 1'b0;
                    dout_d = mem_q[rd_addr];
                    oe_d = 1'b1;
                    rdy_d = 1'b0;
                    cnt_d = HPBA_SETTLE_CYC;
                    state_d = HPBA_RD_WAIT;
                end else if (sel && style_ok && wr_fall && pins_s.read_strobe_n) begin
                    if (burst_q && !first_q && !pins_s.addr_latch_strobe) begin
                        addr_d = next_addr(addr_q);
                    end
                    first_d = 1'b0;
                    state_d = HPBA_WR_ACT;
                end
            end
            HPBA_RD_WAIT: begin
                if (cnt_q <= HPBA_CNT_ONE) begin
                    cnt_d = HPBA_CNT_ZERO;
                    rdy_d = 1'b1;
                    state_d = HPBA_RD_DONE;
                end else begin
                    cnt_d = cnt_q - HPBA_CNT_ONE;
                end
            end
            HPBA_RD_DONE: begin
                if (pins_s.read_strobe_n) begin
                    oe_d = 1'b0;
                    state_d = HPBA_IDLE;
                end
            end
            HPBA_WR_ACT: begin
                if (wr_rise) begin
                    mem_we = 1'b1;
                    state_d = HPBA_IDLE;
                end
            end
            default: begin
                state_d = HPBA_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            pins_q <= PINS_RST;
            state_q <= HPBA_IDLE;
            addr_q <= HPBA_ADDR_RST;
            burst_q <= 1'b0;
            first_q <= 1'b0;
            cnt_q <= HPBA_CNT_ZERO;
            rdy_q <= 1'b1;
            oe_q <= 1'b0;
            dout_q <= HPBA_DATA_RST;
        end else begin
            pins_q <= pins_d;
            state_q <= state_d;
            addr_q <= addr_d;
            burst_q <= burst_d;
            first_q <= first_d;
            cnt_q <= cnt_d;
            rdy_q <= rdy_d;
            oe_q <= oe_d;
            dout_q <= dout_d;
        end
    end

    // store has no reset; contents undefined until written
    always_ff @(posedge core_clk) begin
        if (mem_we) begin
            mem_q[addr_q] <= din_s;
        end
    end

    assign data_out = dout_q;
    assign data_oe = oe_q;
    assign ready_ack = rdy_q;
    assign burst_active = burst_q;
endmodule : hpba_port
`default_nettype wire

// ==== logic/hpba_pkg.sv ====
// shared constants and types for the burst host port
package hpba_pkg;
    localparam int HPBA_AW = 11;
    localparam int HPBA_DW = 8;
    localparam int HPBA_DEPTH = 2048;
    localparam logic [HPBA_AW-1:0] HPBA_ADDR_RST = 11'h000;
    localparam logic [HPBA_AW-1:0] HPBA_ADDR_STEP = 11'h001;
    localparam logic [HPBA_DW-1:0] HPBA_DATA_RST = 8'h00;
    // read data settling time before ready rises
    localparam int HPBA_SETTLE_NS = 40;
    localparam int HPBA_CLK_NS = 10;
    localparam int HPBA_SETTLE_CYC_I = (HPBA_SETTLE_NS + HPBA_CLK_NS - 1) / HPBA_CLK_NS;
    localparam logic [3:0] HPBA_SETTLE_CYC = 4'(HPBA_SETTLE_CYC_I);
    localparam logic [3:0] HPBA_CNT_ZERO = 4'h0;
    localparam logic [3:0] HPBA_CNT_ONE = 4'h1;

    // synchronised host pins
    typedef struct packed {
        logic cs_n;
        logic addr_latch_strobe;
        logic read_strobe_n;
        logic write_strobe_n;
        logic bus_style_select;
    } hpba_pins_t;

    typedef enum logic [1:0] {
        HPBA_IDLE = 2'b00,
        HPBA_RD_WAIT = 2'b01,
        HPBA_RD_DONE = 2'b10,
        HPBA_WR_ACT = 2'b11
    } hpba_state_t;
endpackage : hpba_pkg

// ==== logic/hpba_sync.sv ====
// two-flop synchroniser for a bundle of host pins
`timescale 1ns/1ps
`default_nettype none
module hpba_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // asynchronous in, synchronised out
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            meta_q <= RST_VAL;
            sync_q <= RST_VAL;
        end else begin
            meta_q <= din;
            sync_q <= meta_q;
        end
    end

    assign dout = sync_q;
endmodule : hpba_sync
`default_nettype wire

// ==== sim/hpba_port_monitor.sv ====
// pin-level assertions for the burst host port
`timescale 1ns/1ps
`default_nettype none
module hpba_port_chk
    import hpba_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // host pins
    input wire logic cs_n,
    input wire logic addr_latch_strobe,
    input wire logic read_strobe_n,
    input wire logic write_strobe_n,
    input wire logic bus_style_select,
    // device outputs
    input wire logic [hpba_pkg::HPBA_DW-1:0] data_out,
    input wire logic data_oe,
    input wire logic ready_ack,
    input wire logic burst_active
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);
    a_ready_drop: assert property ($fell(read_strobe_n) && !cs_n && !bus_style_select
        && ready_ack && !data_oe && burst_active |-> ##[2:4] !ready_ack) else $error("no drop");
    a_ready_rise: assert property ($fell(ready_ack) |-> !ready_ack[*4] ##1 ready_ack)
        else $error("bad settle");
    a_oe_on_read: assert property ($fell(ready_ack) |-> data_oe) else $error("oe off");
    a_data_hold: assert property (ready_ack && data_oe && $past(ready_ack) |-> $stable(data_out))
        else $error("data moved");
    a_oe_release: assert property ($rose(read_strobe_n) && data_oe |-> ##[1:5] !data_oe)
        else $error("oe stuck");
    a_no_oe_write: assert property (!write_strobe_n |-> !data_oe) else $error("oe in write");
    a_idle_ready: assert property (!data_oe |-> ready_ack) else $error("ready low idle");
    a_burst_on: assert property ($fell(addr_latch_strobe) && !cs_n && !bus_style_select
        |-> ##[2:4] burst_active) else $error("no burst");
    a_burst_off: assert property ($rose(addr_latch_strobe) |-> ##[2:4] !burst_active)
        else $error("burst stuck");
    a_style_off: assert property (bus_style_select && $past(bus_style_select, 4) |-> !data_oe)
        else $error("style ignored");
    cover property ($rose(ready_ack));
    cover property ($fell(burst_active));
    cover property ($rose(write_strobe_n) && burst_active);
endmodule : hpba_port_chk
bind hpba_port hpba_port_chk hpba_port_chk_inst (
    .core_clk(core_clk),
    .nrst(nrst),
    .cs_n(cs_n),
    .addr_latch_strobe(addr_latch_strobe),
    .read_strobe_n(read_strobe_n),
    .write_strobe_n(write_strobe_n),
    .bus_style_select(bus_style_select),
    .data_out(data_out),
    .data_oe(data_oe),
    .ready_ack(ready_ack),
    .burst_active(burst_active)
);
`default_nettype wire

// ==== sim/hpba_host.sv ====
// host model driving the separate-strobe burst pins
`timescale 1ns/1ps
`default_nettype none
module hpba_host
    import hpba_pkg::*;
(
    // clock
    input wire logic core_clk,
    // pins to the device
    output logic cs_n,
    output logic addr_latch_strobe,
    output logic read_strobe_n,
    output logic write_strobe_n,
    output logic bus_style_select,
    output logic [hpba_pkg::HPBA_AW-1:0] addr,
    output logic [hpba_pkg::HPBA_DW-1:0] data_in,
    // answers
    input wire logic [hpba_pkg::HPBA_DW-1:0] data_out,
    input wire logic ready_ack
);
    initial begin
        cs_n = 1'b1;
        addr_latch_strobe = 1'b0;
        read_strobe_n = 1'b1;
        write_strobe_n = 1'b1;
        bus_style_select = 1'b0;
        addr = 11'h000;
        data_in = 8'h00;
    end
    task automatic hold(input int n);
        repeat (n) @(posedge core_clk);
    endtask : hold
    task automatic sel(input logic c, input logic s);
        cs_n <= c;
        bus_style_select <= s;
        hold(4);
    endtask : sel
    // address pins then stay put for the burst
    task automatic latch(input logic [10:0] a);
        addr <= a;
        cs_n <= 1'b0;
        addr_latch_strobe <= 1'b1;
        hold(4);
        addr_latch_strobe <= 1'b0;
        hold(4);
    endtask : latch
    task automatic stop;
        addr_latch_strobe <= 1'b1;
        hold(4);
    endtask : stop
    task automatic rd(output logic [7:0] d, output logic ok);
        int n = 0;
        read_strobe_n <= 1'b0;
        hold(1);
        while (ready_ack !== 1'b0 && n < 8) begin
            hold(1);
            n++;
        end
        ok = (ready_ack === 1'b0);
        while (ready_ack !== 1'b1 && n < 30) begin
            hold(1);
            n++;
        end
        ok = ok && (ready_ack === 1'b1);
        d = data_out;
        read_strobe_n <= 1'b1;
        hold(4);
    endtask : rd
    task automatic bad_rd(output logic rdy);
        read_strobe_n <= 1'b0;
        hold(8);
        rdy = ready_ack;
        read_strobe_n <= 1'b1;
        hold(4);
    endtask : bad_rd
    task automatic wr(input logic [7:0] d);
        data_in <= d;
        hold(1);
        write_strobe_n <= 1'b0;
        hold(4);
        write_strobe_n <= 1'b1;
        hold(4);
        data_in <= ~d;
        hold(1);
    endtask : wr
endmodule : hpba_host
`default_nettype wire

// ==== sim/tb_top.sv ====
// self-checking bench for the burst host port
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import hpba_pkg::*;
    localparam logic [10:0] BASE = 11'h7FE;
    logic core_clk = 1'b0;
    logic nrst = 1'b0;
    wire logic cs_n, als, rs_n, ws_n, bss, oe, rdy, busy;
    wire logic [10:0] addr;
    wire logic [7:0] din, dout;
    int n_mismatch = 0;
    int checked = 0;
    int cyc = 0;
    int oe_cnt = 0;
    always #5 core_clk = ~core_clk;
    // counts cycles with the data drivers on, for refused accesses
    always @(posedge core_clk) begin
        if (oe === 1'b1) oe_cnt <= oe_cnt + 1;
    end
    hpba_host hpba_host_inst (.core_clk(core_clk), .cs_n(cs_n), .addr_latch_strobe(als),
        .read_strobe_n(rs_n), .write_strobe_n(ws_n), .bus_style_select(bss), .addr(addr),
        .data_in(din), .data_out(dout), .ready_ack(rdy));
    hpba_port hpba_port_inst (.core_clk(core_clk), .nrst(nrst), .cs_n(cs_n),
        .addr_latch_strobe(als), .read_strobe_n(rs_n), .write_strobe_n(ws_n),
        .bus_style_select(bss), .addr(addr), .data_in(din), .data_out(dout), .data_oe(oe),
        .ready_ack(rdy), .burst_active(busy));
    function automatic logic [7:0] pat(input logic [10:0] a);
        return a[7:0] ^ {a[10:8], 5'h15};
    endfunction : pat
    task automatic chk(input string nm, input logic [10:0] seen, input logic [10:0] exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic wrap_up;
        $display("mismatches %0d checks %0d", n_mismatch, checked);
        if (n_mismatch == 0 && checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : wrap_up
    task automatic t_write;
        hpba_host_inst.latch(BASE);
        chk("busy_on", 11'(busy), 11'h001);
        for (int i = 0; i < 4; i++) hpba_host_inst.wr(pat(BASE + 11'(i)));
        hpba_host_inst.stop();
        chk("busy_wr", 11'(busy), 11'h000);
    endtask : t_write
    task automatic t_read(input logic [10:0] b, input int n);
        logic [7:0] d;
        logic ok;
        hpba_host_inst.latch(b);
        for (int i = 0; i < n; i++) begin
            hpba_host_inst.rd(d, ok);
            chk("ready", 11'(ok), 11'h001);
            chk("rd_data", 11'(d), 11'(pat(b + 11'(i))));
        end
        hpba_host_inst.stop();
        chk("busy_rd", 11'(busy), 11'h000);
    endtask : t_read
    task automatic t_refuse;
        int ob;
        logic r;
        hpba_host_inst.latch(BASE);
        hpba_host_inst.sel(1'b1, 1'b0);
        ob = oe_cnt;
        hpba_host_inst.bad_rd(r);
        chk("oe_cs", 11'(oe_cnt - ob), 11'h000);
        chk("rdy_cs", 11'(r), 11'h001);
        hpba_host_inst.sel(1'b0, 1'b1);
        ob = oe_cnt;
        hpba_host_inst.bad_rd(r);
        chk("oe_style", 11'(oe_cnt - ob), 11'h000);
        chk("rdy_style", 11'(r), 11'h001);
        hpba_host_inst.sel(1'b0, 1'b0);
        hpba_host_inst.stop();
    endtask : t_refuse
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            n_mismatch++;
            wrap_up();
        end
    end
    initial begin
        repeat (16) @(posedge core_clk);
        nrst <= 1'b1;
        repeat (4) @(posedge core_clk);
        t_write();
        t_read(BASE, 4);
        t_read(11'h7FF, 2);
        t_refuse();
        wrap_up();
    end
endmodule : tb_top
`default_nettype wire
